// *** hdl/sbcint_unit.sv ***
// Interrupt unit: status, masking and interrupt line timing
//
// Operation
// - Line goes low the next cycle on any unmasked interrupt condition outside a low pulse or gap.
// - Mask bit 0 blocks the line; status bit still sets and reads.
// - Aux regulator undervoltage interrupts on failure onset and on recovery.
// - State-type bits latch at event, hold until read, then take the live state at the read.
// - Chip-failure and wake bits are events, cleared by their read.
// - Read-only command 111 to register 000 releases the line.
// - Wake in register 000; other sources set summary flag there.
// - Summary flag is 0 exactly when registers 001 and 010 are all 0.
// - Read-only command clears the event bits it returns.
// - Several events before a read give one low assertion, all kept.
// - Line low at most the hold time-out, then self-release, status kept.
// - Assertions spaced by the time-out; events in the gap wait.
// - Every low pulse lasts at least the minimum width.
// - Aux regulator switch-on sets its undervolt flag and interrupts.
// - Switch-on undervolt flag not cleared while undervoltage persists.
// - Switched-off aux regulator undervoltage gives no interrupt.
// - Interrupts generated only in normal and stop modes.
// - Leaving restart mode sets every mask bit to enabled.
// - In init before reset output high, line sampled as configuration.
// - Reset-event source active only in software development mode.
// - Hold time-out is 6 ms from the internal clock.
// - Minimum low width is 10 us.
// - All sources enabled after power-up.
`timescale 1ns/100ps
`default_nettype none
`include "sbcint_defines.svh"
module sbcint_unit
  import sbcint_pkg::*;
#(
  parameter int TIMEOUT_CYC = `SBCINT_TIMEOUT_CYC
) (
  input  wire logic                      REF_CLK,
  input  wire logic                      RESET,
  input  wire sbcint_mode_type           MODE,
  input  wire logic                      SWDEV_MODE,
  input  wire logic                      RESET_OUTPUT_PIN,
  input  wire logic [`SBCINT_NSRC-1:0]   SRC_LIVE,
  input  wire logic [`SBCINT_NSRC-1:0]   SRC_IS_STATE,
  input  wire logic [`SBCINT_NSRC-1:0]   SRC_REG2,
  input  wire logic                      AUX2_ON,
  input  wire logic                      AUX3_ON,
  input  wire logic                      AUX2_SWITCH_ON,
  input  wire logic                      AUX3_SWITCH_ON,
  input  wire sbcint_cmd_type            SPI_CMD,
  input  wire logic [`SBCINT_NSRC-1:0]   MASK_WR_DATA,
  input  wire logic                      MASK_WR,
  input  wire logic                      IRQ_PIN_IN,
  output logic                           IRQ_PIN_OUT,
  output logic                           IRQ_PIN_OE,
  output logic [`SBCINT_NSRC-1:0]        STATUS,
  output logic                           SUMMARY_FLAG,
  output logic [`SBCINT_NSRC-1:0]        MASK,
  output logic                           CONFIG_SEL
);
  localparam int MINLOW_CYC = `SBCINT_MINLOW_CYC;

  logic [`SBCINT_NSRC-1:0] live_reg, live_next;
  logic [`SBCINT_NSRC-1:0] status_reg, status_next;
  logic [`SBCINT_NSRC-1:0] mask_reg, mask_next;
  logic [`SBCINT_NSRC-1:0] edge_ev, enabled, rd_clr;
  logic                    summary_reg, summary_next;
  logic                    pend_reg, pend_next;
  logic                    irq_low_reg, irq_low_next;
  logic                    cfg_reg, cfg_next;
  logic                    restart_reg, restart_next;
  logic                    pin_s1_reg, pin_s2_reg;
  logic [19:0]             cnt_reg, cnt_next;
  logic                    rd_int0, rd_fail, new_irq, irq_mode, cfg_sample;
  sbcint_state_type        state_reg, state_next;

  // Sources that may interrupt at all
  always_comb begin
    enabled = '1;
    enabled[`SBCINT_SRC_AUX2_UV]   = AUX2_ON;
    enabled[`SBCINT_SRC_AUX3_UV]   = AUX3_ON;
    enabled[`SBCINT_SRC_RESET_EV]  = SWDEV_MODE;
  end

  assign irq_mode = (MODE == SBCINT_MODE_NORMAL) || (MODE == SBCINT_MODE_STOP);
  assign rd_int0  = SPI_CMD.valid && (SPI_CMD.cmd == `SBCINT_CMD_READ_ONLY)
                    && (SPI_CMD.addr == `SBCINT_REG_WAKE);
  assign rd_fail  = SPI_CMD.valid && (SPI_CMD.cmd == `SBCINT_CMD_READ_ONLY)
                    && ((SPI_CMD.addr == `SBCINT_REG_FAIL1)
                    || (SPI_CMD.addr == `SBCINT_REG_FAIL2));
  assign cfg_sample = (MODE == SBCINT_MODE_INIT) && !RESET_OUTPUT_PIN;

  // Status and masks
  always_comb begin
    live_next = SRC_LIVE & enabled;
    edge_ev   = live_next & ~live_reg;
    // Undervoltage: both edges
    edge_ev[`SBCINT_SRC_AUX2_UV] = ((live_next[`SBCINT_SRC_AUX2_UV]
      ^ live_reg[`SBCINT_SRC_AUX2_UV]) && AUX2_ON) || AUX2_SWITCH_ON;
    edge_ev[`SBCINT_SRC_AUX3_UV] = ((live_next[`SBCINT_SRC_AUX3_UV]
      ^ live_reg[`SBCINT_SRC_AUX3_UV]) && AUX3_ON) || AUX3_SWITCH_ON;
    // Clear by read: register 000 for its bits, 001/010 for the rest
    for (int i = 0; i < `SBCINT_NSRC; i++) begin
      rd_clr[i] = SRC_REG2[i] ? rd_fail : rd_int0;
    end
    status_next = status_reg;
    for (int i = 0; i < `SBCINT_NSRC; i++) begin
      if (rd_clr[i]) begin
        status_next[i] = SRC_IS_STATE[i] & live_next[i];
      end
      if (edge_ev[i] && (live_next[i] || !SRC_IS_STATE[i]
          || i == `SBCINT_SRC_AUX2_UV || i == `SBCINT_SRC_AUX3_UV)) begin
        status_next[i] = 1'b1;
      end
    end
    if (AUX2_SWITCH_ON) status_next[`SBCINT_SRC_AUX2_UV] = 1'b1;
    if (AUX3_SWITCH_ON) status_next[`SBCINT_SRC_AUX3_UV] = 1'b1;
    summary_next = |(status_next & SRC_REG2);
    mask_next = MASK_WR ? MASK_WR_DATA : mask_reg;
    restart_next = (MODE == SBCINT_MODE_RESTART);
    if (restart_reg && !restart_next) begin
      mask_next = `SBCINT_MASK_RESET;
    end
    cfg_next = cfg_sample ? pin_s2_reg : cfg_reg;
  end

  assign new_irq = irq_mode && |(edge_ev & mask_reg);

  // Line timing
  always_comb begin
    state_next   = state_reg;
    cnt_next     = (cnt_reg != '0) ? cnt_reg - 20'h1 : cnt_reg;
    pend_next    = pend_reg | new_irq;
    irq_low_next = irq_low_reg;
    case (state_reg)
      SBCINT_IDLE: begin
        if (pend_next) begin
          state_next   = SBCINT_LOW;
          irq_low_next = 1'b1;
          pend_next    = 1'b0;
          cnt_next     = 20'(TIMEOUT_CYC - 1);
        end
      end
      SBCINT_LOW: begin
        pend_next = 1'b0;
        if ((rd_int0 && (20'(TIMEOUT_CYC) - cnt_reg) >= 20'(MINLOW_CYC))
            || cnt_reg == '0) begin
          state_next   = SBCINT_GAP;
          irq_low_next = 1'b0;
          cnt_next     = 20'(TIMEOUT_CYC - 1);
        end
      end
      SBCINT_GAP: begin
        if (cnt_reg == '0) state_next = SBCINT_IDLE;
      end
      default: state_next = SBCINT_IDLE;
    endcase
    if (!irq_mode) begin
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      live_reg    <= '0;
      status_reg  <= '0;
      mask_reg    <= `SBCINT_MASK_RESET;
      summary_reg <= 1'b0;
      pend_reg    <= 1'b0;
      irq_low_reg <= 1'b0;
      cfg_reg     <= 1'b0;
      restart_reg <= 1'b0;
      pin_s1_reg  <= 1'b1;
      pin_s2_reg  <= 1'b1;
      cnt_reg     <= '0;
      state_reg   <= SBCINT_IDLE;
    end else begin
      live_reg    <= live_next;
      status_reg  <= status_next;
      mask_reg    <= mask_next;
      summary_reg <= summary_next;
      pend_reg    <= pend_next;
      irq_low_reg <= irq_low_next;
      cfg_reg     <= cfg_next;
      restart_reg <= restart_next;
      pin_s1_reg  <= IRQ_PIN_IN;
      pin_s2_reg  <= pin_s1_reg;
      cnt_reg     <= cnt_next;
      state_reg   <= state_next;
    end
  end

  assign IRQ_PIN_OUT  = 1'b0;
  assign IRQ_PIN_OE   = irq_low_reg;
  assign STATUS       = status_reg;
  assign SUMMARY_FLAG = summary_reg;
  assign MASK         = mask_reg;
  assign CONFIG_SEL   = cfg_reg;

  // Assertion helpers: length of low pulse and of gap
  logic [19:0] oe_len_reg, oe_len_next;
  logic [19:0] gap_len_reg, gap_len_next;

  always_comb begin
    oe_len_next  = irq_low_reg ? oe_len_reg + 20'h1 : '0;
    gap_len_next = gap_len_reg;
    if (irq_low_reg) gap_len_next = '0;
    else if (gap_len_reg != '1) gap_len_next = gap_len_reg + 20'h1;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      oe_len_reg  <= '0;
      gap_len_reg <= '1;
    end else begin
      oe_len_reg  <= oe_len_next;
      gap_len_reg <= gap_len_next;
    end
  end

  // Assertions
  low_on_event_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (state_reg == SBCINT_IDLE && new_irq) |=> IRQ_PIN_OE)
    else $error("line not driven after event");
  masked_quiet_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (state_reg == SBCINT_IDLE && !pend_reg && !new_irq) |=> !IRQ_PIN_OE)
    else $error("line driven without cause");
  summary_flag_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    SUMMARY_FLAG == |(STATUS & $past(SRC_REG2)))
    else $error("summary flag mismatch");
  sequence low_start_s;
    $rose(IRQ_PIN_OE);
  endsequence
  min_width_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    low_start_s |-> IRQ_PIN_OE [*8])
    else $error("pulse too short");
  release_gap_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    $fell(IRQ_PIN_OE) |-> !IRQ_PIN_OE [*8])
    else $error("assertions too close");
  timeout_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (IRQ_PIN_OE && cnt_reg == '0 && state_reg == SBCINT_LOW) |=> !IRQ_PIN_OE)
    else $error("no release at time-out");
  mode_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    !irq_mode |=> !pend_reg)
    else $error("pending outside allowed modes");
  mask_restart_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (restart_reg && MODE != SBCINT_MODE_RESTART) |=> MASK == `SBCINT_MASK_RESET)
    else $error("masks not enabled after restart");
  switch_on_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    AUX2_SWITCH_ON |=> STATUS[`SBCINT_SRC_AUX2_UV])
    else $error("switch-on flag not set");
  // Counter-based pulse and gap checks, then status, source, mode and merge checks
  sequence low_end_s;
    $fell(IRQ_PIN_OE);
  endsequence
  hold_limit_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    IRQ_PIN_OE |-> oe_len_reg < 20'(TIMEOUT_CYC))
    else $error("line held past time-out");
  min_len_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    low_end_s |-> oe_len_reg >= 20'(MINLOW_CYC))
    else $error("low pulse shorter than minimum");
  gap_len_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    low_start_s |-> gap_len_reg >= 20'(TIMEOUT_CYC))
    else $error("gap shorter than time-out");
  read_release_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (IRQ_PIN_OE && rd_int0 && oe_len_reg >= 20'(MINLOW_CYC)) |=> !IRQ_PIN_OE)
    else $error("line not released by read");
  gap_quiet_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (state_reg == SBCINT_GAP) |-> !IRQ_PIN_OE)
    else $error("line driven in gap");
  wake_clear_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (rd_int0 && !SRC_REG2[0] && !SRC_IS_STATE[0] && !edge_ev[0]) |=> !STATUS[0])
    else $error("event bit not cleared by read");
  uv_keep_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (rd_fail && SRC_REG2[`SBCINT_SRC_AUX2_UV] && SRC_IS_STATE[`SBCINT_SRC_AUX2_UV]
      && live_next[`SBCINT_SRC_AUX2_UV]) |=> STATUS[`SBCINT_SRC_AUX2_UV])
    else $error("undervolt flag cleared while present");
  aux2_off_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (!AUX2_ON && !AUX2_SWITCH_ON) |-> !edge_ev[`SBCINT_SRC_AUX2_UV])
    else $error("event from switched-off regulator");
  aux3_off_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (!AUX3_ON && !AUX3_SWITCH_ON) |-> !edge_ev[`SBCINT_SRC_AUX3_UV])
    else $error("event from switched-off regulator");
  reset_src_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    !SWDEV_MODE |-> !edge_ev[`SBCINT_SRC_RESET_EV])
    else $error("reset event outside development mode");
  event_status_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (|edge_ev) |=> ((STATUS & $past(edge_ev)) == $past(edge_ev)))
    else $error("status bit not set at event");
  cfg_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    !cfg_sample |=> $stable(CONFIG_SEL))
    else $error("configuration changed outside sampling");
  aux3_switch_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    AUX3_SWITCH_ON |=> STATUS[`SBCINT_SRC_AUX3_UV])
    else $error("switch-on flag not set");
  no_irq_mode_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (!irq_mode && state_reg == SBCINT_IDLE && !pend_reg) |=> !IRQ_PIN_OE)
    else $error("line driven outside allowed modes");
  merge_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (state_reg == SBCINT_LOW) |=> !pend_reg)
    else $error("event while low not merged");
  summary_clear_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    ((STATUS & $past(SRC_REG2)) == '0) |-> !SUMMARY_FLAG)
    else $error("summary flag set without cause");
endmodule : sbcint_unit
`default_nettype wire

// *** shared/sbcint_defines.svh ***
// Constants of the interrupt unit
`ifndef SBCINT_DEFINES_SVH
`define SBCINT_DEFINES_SVH
`define SBCINT_CLK_MHZ        100
`define SBCINT_TIMEOUT_US     6000
`define SBCINT_TIMEOUT_CYC    (`SBCINT_TIMEOUT_US * `SBCINT_CLK_MHZ)
`define SBCINT_MINLOW_US      10
`define SBCINT_MINLOW_CYC     (`SBCINT_MINLOW_US * `SBCINT_CLK_MHZ)
`define SBCINT_CMD_READ_ONLY  3'h7
`define SBCINT_REG_WAKE       3'h0
`define SBCINT_REG_FAIL1      3'h1
`define SBCINT_REG_FAIL2      3'h2
`define SBCINT_NSRC           16
`define SBCINT_MASK_RESET     16'hffff
`define SBCINT_SRC_AUX2_UV    3
`define SBCINT_SRC_AUX3_UV    4
`define SBCINT_SRC_RESET_EV   9
`endif

// *** shared/sbcint_pkg.sv ***
// Types of the interrupt unit
package sbcint_pkg;
  typedef enum logic [2:0] {
    SBCINT_MODE_INIT    = 3'h0,
    SBCINT_MODE_NORMAL  = 3'h1,
    SBCINT_MODE_STOP    = 3'h2,
    SBCINT_MODE_SLEEP   = 3'h3,
    SBCINT_MODE_RESTART = 3'h4,
    SBCINT_MODE_FAILSAFE= 3'h5,
    SBCINT_MODE_FLASH   = 3'h6
  } sbcint_mode_type;
  typedef enum logic [1:0] {
    SBCINT_IDLE = 2'h0,
    SBCINT_LOW  = 2'h1,
    SBCINT_GAP  = 2'h2
  } sbcint_state_type;
  typedef struct packed {
    logic       valid;
    logic [2:0] cmd;
    logic [2:0] addr;
  } sbcint_cmd_type;
endpackage : sbcint_pkg

// *** tb/sbcint_host.sv ***
// Host model: answers the interrupt line with read-only commands
`timescale 1ns/100ps
`default_nettype none
`include "sbcint_defines.svh"
module sbcint_host
  import sbcint_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          pin,
  input  wire logic          auto_en,
  input  wire logic [2:0]    rd_addr,
  input  wire logic          rd_req,
  output var sbcint_cmd_type cmd
);
  localparam int DLY = 1100;
  localparam sbcint_cmd_type REL = '{1'b1, `SBCINT_CMD_READ_ONLY, `SBCINT_REG_WAKE};
  int low_n = 0;
  initial cmd = '0;
  always @(posedge clk) begin
    low_n <= pin ? 0 : low_n + 1;
    cmd <= '0;
    if (rd_req) cmd <= '{1'b1, `SBCINT_CMD_READ_ONLY, rd_addr};
    else if (auto_en && low_n == DLY) cmd <= REL;
  end
endmodule : sbcint_host
`default_nettype wire

// *** tb/sbcint_unit_test.sv ***
// Testbench of the interrupt unit
`timescale 1ns/100ps
`default_nettype none
`include "sbcint_defines.svh"
module sbcint_unit_test;
  import sbcint_pkg::*;
  localparam int TO = 2000;
  localparam int ML = `SBCINT_MINLOW_CYC;
  typedef struct {int idx; bit msk; sbcint_mode_type md; bit oe; bit st;} sbcint_row_type;
  sbcint_row_type rows [4] = '{'{0, 0, SBCINT_MODE_NORMAL, 1, 1}, '{5, 0, SBCINT_MODE_STOP, 1, 1},
    '{10, 1, SBCINT_MODE_NORMAL, 0, 1}, '{12, 0, SBCINT_MODE_SLEEP, 0, 1}};
  logic clk = 0, rst = 1, mwr = 0, aon2 = 0, sw2 = 0, rop = 0, cfg = 0, ae = 1, rq = 0;
  logic swdev = 0;
  logic [2:0] rd_addr = 3'h0;
  logic [15:0] live = 16'h0, mwd = 16'hffff, status, mask;
  logic oe, pout, summ, csel, oe_d = 0;
  sbcint_mode_type mode = SBCINT_MODE_INIT;
  sbcint_cmd_type cmd;
  int fails = 0, n_checks = 0, w = 0, g = TO, rises = 0, r0 = 0, cyc_n = 0;
  wire pin = oe ? pout : cfg;
  always #5 clk = ~clk;
  sbcint_unit #(.TIMEOUT_CYC(TO)) dut (.REF_CLK(clk), .RESET(rst), .MODE(mode),
    .SWDEV_MODE(swdev), .RESET_OUTPUT_PIN(rop), .SRC_LIVE(live), .SRC_IS_STATE(16'h00f8),
    .SRC_REG2(16'hfff8), .AUX2_ON(aon2), .AUX3_ON(1'b0), .AUX2_SWITCH_ON(sw2),
    .AUX3_SWITCH_ON(1'b0), .SPI_CMD(cmd), .MASK_WR_DATA(mwd), .MASK_WR(mwr),
    .IRQ_PIN_IN(pin), .IRQ_PIN_OUT(pout), .IRQ_PIN_OE(oe), .STATUS(status),
    .SUMMARY_FLAG(summ), .MASK(mask), .CONFIG_SEL(csel));
  sbcint_host host (.clk(clk), .pin(pin), .auto_en(ae), .rd_addr(rd_addr), .rd_req(rq),
    .cmd(cmd));
  task automatic final_report;
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic pulse(input int k);
    live[k] = 1'b1;
    cyc(1);
    live[k] = 1'b0;
  endtask : pulse
  task automatic rd(input logic [2:0] a);
    rd_addr = a;
    rq = 1'b1;
    cyc(1);
    rq = 1'b0;
    cyc(2);
  endtask : rd
  // Pulse width and spacing monitor
  always @(posedge clk) begin
    oe_d <= oe;
    w <= oe ? w + 1 : 0;
    g <= oe ? 0 : g + 1;
    if (oe && !oe_d) begin
      rises <= rises + 1;
      chk(16'(g >= TO - 1), 16'h1);
    end
    if (!oe && oe_d) chk(16'(w >= ML && w <= TO), 16'h1);
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    cyc(2);
    rst = 0;
    chk(mask, 16'hffff);
    chk(status, 16'h0);
    chk(16'({oe, summ}), 16'h0);
    cfg = 1;
    cyc(5);
    chk(16'(csel), 16'h1);
    rop = 1;
    cfg = 0;
    cyc(5);
    chk(16'(csel), 16'h1);
    cfg = 1;
    mwd = 16'h0;
    mwr = 1;
    cyc(1);
    mwr = 0;
    mode = SBCINT_MODE_RESTART;
    cyc(2);
    mode = SBCINT_MODE_NORMAL;
    cyc(2);
    chk(mask, 16'hffff);
    foreach (rows[i]) begin
      mwd = rows[i].msk ? ~(16'h1 << rows[i].idx) : 16'hffff;
      mwr = 1;
      mode = rows[i].md;
      cyc(1);
      mwr = 0;
      pulse(rows[i].idx);
      cyc(2);
      chk(16'(oe), 16'(rows[i].oe));
      if (rows[i].st) chk(16'(status[rows[i].idx]), 16'h1);
      chk(16'(summ), 16'(rows[i].st && rows[i].idx > 2));
      rd(`SBCINT_REG_FAIL1);
      rd(`SBCINT_REG_FAIL2);
      cyc(3500);
      chk(16'(status[rows[i].idx]), 16'h0);
      chk(16'(summ), 16'h0);
    end
    mode = SBCINT_MODE_NORMAL;
    ae = 0;
    r0 = rises;
    pulse(1);
    cyc(5);
    pulse(2);
    cyc(2100);
    chk(16'(oe), 16'h0);
    chk(16'(status[2:1]), 16'h3);
    chk(16'(rises - r0), 16'h1);
    pulse(0);
    cyc(2);
    chk(16'(oe), 16'h0);
    cyc(2000);
    chk(16'(oe), 16'h1);
    cyc(1000);
    rd(`SBCINT_REG_WAKE);
    cyc(1);
    chk(16'(oe), 16'h0);
    chk(16'(status[2:0]), 16'h0);
    cyc(2100);
    pulse(0);
    rd(`SBCINT_REG_WAKE);
    chk(16'(status[0]), 16'h0);
    cyc(500);
    chk(16'(oe), 16'h1);
    cyc(3600);
    pulse(4);
    cyc(2);
    chk(16'(oe), 16'h0);
    ae = 1;
    r0 = rises;
    aon2 = 1;
    live[3] = 1;
    sw2 = 1;
    cyc(1);
    sw2 = 0;
    cyc(2);
    chk(16'({status[3], oe}), 16'h3);
    rd(`SBCINT_REG_FAIL1);
    chk(16'(status[3]), 16'h1);
    cyc(1200);
    live[3] = 0;
    cyc(3500);
    chk(16'(rises - r0), 16'h2);
    pulse(9);
    cyc(2);
    chk(16'(status[9]), 16'h0);
    swdev = 1;
    cyc(1600);
    pulse(9);
    cyc(2);
    chk(16'({status[9], oe}), 16'h3);
    final_report();
  end
endmodule : sbcint_unit_test
`default_nettype wire
